/* File: rsc_pkg.sv */
// constants for the system reset combiner
// Operation
// - system reset output is active at once on power-on, one clock after any other source, two clocks more for pin and brown-out
// - sources: power-on, brown-out, clear pin, instruction, watchdog, mismatch, trap, illegal
// - each reset kind sets its own cause flag in the status register
// - power-on clears all cause flags except power-on and brown-out, which it sets
// - software may set or clear any flag; setting never starts a reset
// - every reset copies the default oscillator field into the new oscillator select
// - reset forces selected registers to defaults and leaves the others unchanged
package rsc_pkg;
   localparam int STAT_W = 8;
   localparam int OSC_W = 3;
   localparam int POR_BIT = 0;
   localparam int BROWN_OUT_BIT = 1;
   localparam int CLR_PIN_BIT = 2;
   localparam int INSTR_BIT = 3;
   localparam int WDT_BIT = 4;
   localparam int MISMATCH_BIT = 5;
   localparam int TRAP_BIT = 6;
   localparam int ILL_BIT = 7;
   localparam logic [STAT_W-1:0] STAT_POR_VAL = 8'h03;
   localparam logic [OSC_W-1:0] OSC_RST_VAL = 3'h0;
endpackage

/* File: rsc_top.sv */
// system reset combiner with cause flags and oscillator select load
module rsc_top #(
   // cause flags sit at fixed positions, so these widths are checked below
   parameter int STAT_W = rsc_pkg::STAT_W,
   parameter int OSC_W = rsc_pkg::OSC_W
) (
   // clock and power-on reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // asynchronous reset sources from pins and analog
   input wire logic brown_out_reset_in,
   input wire logic external_clear_pin_reset_n_in,
   // synchronous reset sources from core logic
   input wire logic reset_instruction_in,
   input wire logic watchdog_timeout_reset_in,
   input wire logic config_mismatch_reset_in,
   input wire logic trap_conflict_reset_in,
   input wire logic illegal_opcode_in,
   input wire logic uninit_wreg_in,
   input wire logic security_reset_in,
   // software access to the reset status register
   input wire logic [STAT_W-1:0] status_set_in,
   input wire logic [STAT_W-1:0] status_clr_in,
   output logic [STAT_W-1:0] reset_status_register_out,
   // oscillator control
   input wire logic [OSC_W-1:0] default_oscillator_field_in,
   input wire logic osc_wr_in,
   input wire logic [OSC_W-1:0] osc_wr_data_in,
   output logic [OSC_W-1:0] new_oscillator_select_out,
   // combined reset
   output logic system_reset_out
);
   logic brown_meta_r;
   logic brown_sync_r;
   logic clr_meta_r;
   logic clr_sync_r;
   logic illegal_condition_reset;
   logic src_any;
   logic [STAT_W-1:0] events;
   logic [STAT_W-1:0] status_r;
   logic [STAT_W-1:0] status_nxt;
   logic [OSC_W-1:0] osc_sel_r;
   logic sys_reset_r;
   logic por_first_r;

   // one flag per cause kind, so the status width cannot move
   if (STAT_W != rsc_pkg::STAT_W) begin : g_stat_w_check
      $error("status width must equal the number of cause flags");
   end

   // the select field is loaded straight from the configuration field
   if (OSC_W != rsc_pkg::OSC_W) begin : g_osc_w_check
      $error("oscillator select width must equal the configuration field");
   end

   // analog and pin sources cross into the clock domain
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         brown_meta_r <= 1'b0;
         brown_sync_r <= 1'b0;
         // pin idles high, so its stages reset high: no false clear at release
         clr_meta_r <= 1'b1;
         clr_sync_r <= 1'b1;
      end else begin
         brown_meta_r <= brown_out_reset_in;
         brown_sync_r <= brown_meta_r;
         clr_meta_r <= external_clear_pin_reset_n_in;
         clr_sync_r <= clr_meta_r;
      end
   end

   // three illegal conditions share one cause flag
   assign illegal_condition_reset = illegal_opcode_in | uninit_wreg_in | security_reset_in;

   always_comb begin
      events = '0;
      events[rsc_pkg::BROWN_OUT_BIT] = brown_sync_r;
      events[rsc_pkg::CLR_PIN_BIT] = !clr_sync_r;
      events[rsc_pkg::INSTR_BIT] = reset_instruction_in;
      events[rsc_pkg::WDT_BIT] = watchdog_timeout_reset_in;
      events[rsc_pkg::MISMATCH_BIT] = config_mismatch_reset_in;
      events[rsc_pkg::TRAP_BIT] = trap_conflict_reset_in;
      events[rsc_pkg::ILL_BIT] = illegal_condition_reset;
   end

   assign src_any = |events;

   // hardware events and software sets win over a software clear
   assign status_nxt = (status_r & ~status_clr_in) | status_set_in | events;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         status_r <= rsc_pkg::STAT_POR_VAL;
      end else begin
         status_r <= status_nxt;
      end
   end

   // registered so release lines up with the clock; flags play no part
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sys_reset_r <= 1'b1;
      end else begin
         sys_reset_r <= src_any;
      end
   end

   // configuration field cannot be loaded asynchronously, so load while reset holds
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         osc_sel_r <= rsc_pkg::OSC_RST_VAL;
      end else if (sys_reset_r) begin
         osc_sel_r <= default_oscillator_field_in;
      end else if (osc_wr_in) begin
         osc_sel_r <= osc_wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         por_first_r <= 1'b1;
      end else begin
         por_first_r <= 1'b0;
      end
   end

   assign system_reset_out = sys_reset_r;
   assign reset_status_register_out = status_r;
   assign new_oscillator_select_out = osc_sel_r;

   a_any_source_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
      src_any |=> system_reset_out)
      else $error("active source did not assert system reset");

   a_mismatch_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (config_mismatch_reset_in || uninit_wreg_in) |=> system_reset_out)
      else $error("mismatch or illegal source ignored");

   a_cause_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      trap_conflict_reset_in |=> reset_status_register_out[rsc_pkg::TRAP_BIT])
      else $error("trap cause flag not set");

   a_por_flags_value: assert property (@(posedge clk_in) disable iff (!nrst_in)
      por_first_r |-> reset_status_register_out == rsc_pkg::STAT_POR_VAL)
      else $error("power-on flags wrong");

   a_sw_set_noreset: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (status_set_in != '0 && !src_any) |=> !system_reset_out
         && ((reset_status_register_out & $past(status_set_in)) == $past(status_set_in)))
      else $error("software set misbehaved");

   a_osc_load_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
      system_reset_out |=> new_oscillator_select_out == $past(default_oscillator_field_in))
      else $error("oscillator select not loaded on reset");

   a_flags_retained: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (system_reset_out && status_clr_in == '0) |=>
         (reset_status_register_out & $past(reset_status_register_out))
         == $past(reset_status_register_out))
      else $error("status lost during reset");

   a_release_sync: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!src_any && !watchdog_timeout_reset_in) [*2] |=> !system_reset_out)
      else $error("reset held with no source");

   // release may only follow a cycle in which every source was quiet
   a_release_all_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(system_reset_out) |-> !$past(src_any))
      else $error("system reset released while a source was active");

   a_quiet_releases: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !src_any |=> !system_reset_out)
      else $error("system reset held one cycle past the last source");

   a_por_holds_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
      por_first_r |-> system_reset_out)
      else $error("system reset not active right after power-on");

   // synchronised sources need two extra edges before they count
   a_pin_reset_path: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!external_clear_pin_reset_n_in) [*3] |=> system_reset_out)
      else $error("clear pin did not assert system reset");

   a_brown_reset_path: assert property (@(posedge clk_in) disable iff (!nrst_in)
      brown_out_reset_in [*3] |=> system_reset_out)
      else $error("brown-out did not assert system reset");

   a_trap_resets: assert property (@(posedge clk_in) disable iff (!nrst_in)
      trap_conflict_reset_in |=> system_reset_out)
      else $error("trap conflict did not assert system reset");

   a_pin_cause_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!external_clear_pin_reset_n_in) [*3] |=>
         reset_status_register_out[rsc_pkg::CLR_PIN_BIT])
      else $error("clear pin cause flag not set");

   a_brown_cause_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
      brown_out_reset_in [*3] |=> reset_status_register_out[rsc_pkg::BROWN_OUT_BIT])
      else $error("brown-out cause flag not set");

   a_instr_cause_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
      reset_instruction_in |=> reset_status_register_out[rsc_pkg::INSTR_BIT])
      else $error("instruction cause flag not set");

   a_wdt_cause_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
      watchdog_timeout_reset_in |=> reset_status_register_out[rsc_pkg::WDT_BIT])
      else $error("watchdog cause flag not set");

   a_mismatch_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
      config_mismatch_reset_in |=> reset_status_register_out[rsc_pkg::MISMATCH_BIT])
      else $error("mismatch cause flag not set");

   a_illegal_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (illegal_opcode_in || uninit_wreg_in || security_reset_in) |=>
         reset_status_register_out[rsc_pkg::ILL_BIT])
      else $error("illegal condition cause flag not set");

   // only power-on or a software write may raise the power-on flag
   a_power_flag_only: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!status_set_in[rsc_pkg::POR_BIT] && !reset_status_register_out[rsc_pkg::POR_BIT])
         |=> !reset_status_register_out[rsc_pkg::POR_BIT])
      else $error("power-on flag raised without power-on");

   a_sw_clear_works: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (status_set_in == '0 && events == '0) |=> reset_status_register_out
         == ($past(reset_status_register_out) & ~$past(status_clr_in)))
      else $error("software clear misbehaved");

   // outside reset the select only moves on a software write
   a_osc_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!system_reset_out && !osc_wr_in) |=> $stable(new_oscillator_select_out))
      else $error("oscillator select changed without reset or write");
endmodule

/* File: rsc_src_model.sv */
// model of all nine reset sources feeding the combiner, clear pin and brown-out included
module rsc_src_model (
   // requests from the bench, one bit per source
   input wire logic [8:0] req_in,
   // source levels, bit 1 is the active-low clear pin
   output logic [8:0] src_out
);
   // pin idles high through its pull-up, so only its level is inverted
   assign src_out = req_in ^ 9'h002;
endmodule

/* File: tb_rsc_top.sv */
// self-checking bench for the system reset combiner
module tb_rsc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, nrst_in = 0, osc_wr_in = 0, sr;
   logic [8:0] req = '0, src;
   logic [7:0] set_v = '0, clr_v = '0, st;
   logic [2:0] dflt = 3'h6, wdat = 3'h5, new_osc;
   int num_errors = 0, n_compared = 0;
   always #4 clk_in = ~clk_in;
   rsc_src_model src_u (.req_in(req), .src_out(src));
   rsc_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .brown_out_reset_in(src[0]),
      .external_clear_pin_reset_n_in(src[1]), .reset_instruction_in(src[2]),
      .watchdog_timeout_reset_in(src[3]), .config_mismatch_reset_in(src[4]),
      .trap_conflict_reset_in(src[5]), .illegal_opcode_in(src[6]),
      .uninit_wreg_in(src[7]), .security_reset_in(src[8]), .status_set_in(set_v),
      .status_clr_in(clr_v), .reset_status_register_out(st),
      .default_oscillator_field_in(dflt), .osc_wr_in(osc_wr_in),
      .osc_wr_data_in(wdat), .new_oscillator_select_out(new_osc), .system_reset_out(sr));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic t_por;
      repeat (2) @(negedge clk_in);
      chk("status", 8'h03, st);
      chk("osc_sel", {5'h0, dflt}, {5'h0, new_osc});
      chk("system_reset_out", 8'h00, {7'h0, sr});
      $display("done por");
   endtask
   // sync and pin sources share one hold time, long enough for the pin synchroniser
   task automatic t_src;
      for (int i = 0; i < 9; i++) begin
         clr_v = 8'hff;
         osc_wr_in = 1;
         @(negedge clk_in);
         clr_v = '0;
         osc_wr_in = 0;
         @(negedge clk_in);
         chk("osc_wr", {5'h0, wdat}, {5'h0, new_osc});
         req[i] = 1;
         repeat (4) @(negedge clk_in);
         chk("system_reset_out_on", 8'h01, {7'h0, sr});
         req = '0;
         repeat (6) @(negedge clk_in);
         chk("system_reset_out_off", 8'h00, {7'h0, sr});
         chk("cause", 8'h01 << ((i < 6) ? i + 1 : 7), st);
         chk("osc_rst", {5'h0, dflt}, {5'h0, new_osc});
      end
      $display("done sources");
   endtask
   task automatic t_sw;
      set_v = 8'hfc;
      @(negedge clk_in);
      set_v = '0;
      clr_v = 8'h03;
      @(negedge clk_in);
      clr_v = '0;
      chk("sw_set", 8'hfc, st);
      repeat (3) @(negedge clk_in);
      chk("sw_norst", 8'h00, {7'h0, sr});
      // second power-on with flags set: all but the two low flags must go
      nrst_in = 0;
      @(negedge clk_in);
      nrst_in = 1;
      repeat (2) @(negedge clk_in);
      chk("por_again", 8'h03, st);
      chk("osc_again", {5'h0, dflt}, {5'h0, new_osc});
      chk("rst_again", 8'h00, {7'h0, sr});
      clr_v = 8'hff;
      @(negedge clk_in);
      clr_v = '0;
      chk("sw_clr", 8'h00, st);
      $display("done software");
   endtask
   initial begin
      #20000;
      num_errors++;
      conclude;
   end
   initial begin
      repeat (3) @(negedge clk_in);
      nrst_in = 1;
      t_por;
      t_src;
      t_sw;
      conclude;
   end
endmodule
